// ===== bench/omd_decoder_properties.sv
// Checker for the opcode map decoder: decode, address and control relations.
// Assumes it is bound to omd_decoder and sees only its ports.
`timescale 1ns/100ps
module omd_decoder_properties
    import omd_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_byte_valid,
    input wire logic [OMD_OP_W-1:0] i_byte,
    input wire logic [OMD_OP_W-1:0] i_index_reg,
    input wire logic [ADDR_W-1:0] i_pc_next,
    input wire logic i_branch_cond,
    input wire omd_decode_s o_dec,
    input wire omd_ctl_s o_ctl,
    input wire logic [ADDR_W-1:0] o_eff_addr,
    input wire logic [ADDR_W-1:0] o_branch_target,
    input wire logic o_branch_take,
    input wire logic o_done,
    input wire logic o_illegal
);
    logic [7:0] b1, b2, idx;
    logic [ADDR_W-1:0] pc;
    logic cond;
    logic [ADDR_W+24:0] next_hist;
    logic [ADDR_W-1:0] rel_tgt;
    // Last two taken bytes and the inputs sampled with the last one
    always_comb begin
        next_hist = {b1, b2, idx, pc, cond};
        if (i_byte_valid) begin
            next_hist = {i_byte, b1, i_index_reg, i_pc_next, i_branch_cond};
        end
    end
    always_ff @(posedge i_core_clk) begin
        {b1, b2, idx, pc, cond} <= next_hist;
    end
    assign rel_tgt = pc + {{(ADDR_W-8){b1[7]}}, b1};
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    AST_MOVE_CTL:
        assert property (o_ctl.index_to_acc_move |-> o_done && o_ctl.keep_flags
            && !o_ctl.clear_imask && o_dec.cycles == 4'h2) else $error("bad move pulse");
    AST_WAIT_CTL:
        assert property (o_ctl.halt_cpu_clk && !o_ctl.halt_osc |-> o_done
            && o_ctl.clear_imask && !o_ctl.irq_pin_enable) else $error("bad wait pulse");
    AST_STOP_CTL:
        assert property (o_ctl.halt_osc |-> o_done && o_ctl.clear_imask
            && o_ctl.irq_pin_enable) else $error("bad stop pulse");
    AST_ILLEGAL:
        assert property (o_illegal |-> o_done && !o_dec.legal) else $error("bad illegal");
    AST_ROW:
        assert property (o_done && o_dec.len == 2'h1 |-> o_dec.row == b1[3:0])
        else $error("row is not low nibble");
    AST_EXT_ADDR:
        assert property (o_done && o_dec.mode == OMD_MODE_EXTENDED
            |-> o_eff_addr == ADDR_W'({b2, b1})) else $error("bad extended address");
    AST_WIDE_ADDR:
        assert property (o_done && o_dec.mode == OMD_MODE_IDX_WIDE
            |-> o_eff_addr == ADDR_W'({b2, b1}) + ADDR_W'(idx)) else $error("bad wide address");
    AST_BYTE_ADDR:
        assert property (o_done && o_dec.mode == OMD_MODE_IDX_BYTE
            |-> o_eff_addr == ADDR_W'(b1) + ADDR_W'(idx)) else $error("bad byte address");
    AST_REL:
        assert property (o_done && o_dec.mode inside {OMD_MODE_RELATIVE, OMD_MODE_DIR_REL}
            |-> o_branch_target == rel_tgt && o_branch_take == cond) else $error("bad branch");
    AST_BIT_BRANCH:
        assert property (o_done && o_dec.mode == OMD_MODE_DIR_REL |-> o_dec.len == 2'h3
            && o_dec.cycles == 4'h5 && o_eff_addr == ADDR_W'(b2)) else $error("bad bit branch");
endmodule
bind omd_decoder omd_decoder_properties #(.ADDR_W(ADDR_W)) i_omd_decoder_properties (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .i_index_reg(i_index_reg), .i_pc_next(i_pc_next), .i_branch_cond(i_branch_cond),
    .o_dec(o_dec), .o_ctl(o_ctl), .o_eff_addr(o_eff_addr), .o_branch_target(o_branch_target),
    .o_branch_take(o_branch_take), .o_done(o_done), .o_illegal(o_illegal));

// ===== bench/omd_decoder_test.sv
// Bench for the opcode map decoder: one task per scenario, self-checking.
// Assumes omd_pkg, the program memory model and the checker are compiled first.
`timescale 1ns/100ps
module omd_decoder_test
    import omd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic bv;
    logic [7:0] bd;
    logic [7:0] idx = 8'h00;
    logic [15:0] pc = 16'h0000;
    logic cond = 1'b0;
    omd_decode_s dec;
    omd_ctl_s ctl;
    logic [15:0] ea;
    logic [15:0] tgt;
    logic take;
    logic done;
    logic ill;
    int mismatches = 0;
    int checks = 0;
    always #25 clk = ~clk;
    omd_prog_mem i_omd_prog_mem (.i_core_clk(clk), .i_rst(rst), .i_slow(slow),
        .o_byte_valid(bv), .o_byte(bd));
    omd_decoder #(.ADDR_W(16)) i_omd_decoder (.i_core_clk(clk), .i_rst(rst),
        .i_byte_valid(bv), .i_byte(bd), .i_index_reg(idx), .i_pc_next(pc),
        .i_branch_cond(cond), .o_dec(dec), .o_ctl(ctl), .o_eff_addr(ea),
        .o_branch_target(tgt), .o_branch_take(take), .o_done(done), .o_illegal(ill));
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One instruction of n bytes, then a bounded wait for done
    task automatic run(input logic [23:0] b, input int n, input logic [7:0] x,
            input logic [15:0] p, input logic c, input logic s);
        int k;
        @(posedge clk);
        idx <= x;
        pc <= p;
        cond <= c;
        slow <= s;
        @(negedge clk);
        for (k = 0; k < n; k++) begin
            i_omd_prog_mem.load(b[23-8*k -: 8]);
        end
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) break;
        end
        if (k == 20) begin
            mismatches++;
            $display("unexpected done: expected 1 seen timeout");
            end_sim();
        end
    endtask
    task automatic t_control();
        run(24'h9f0000, 1, 8'h5a, 16'h0, 1'b0, 1'b0);
        check("move", {ctl.index_to_acc_move, ctl.keep_flags, ctl.clear_imask}, 20'h6);
        check("move cycles", dec.cycles, 20'h2);
        run(24'h8f0000, 1, 8'h00, 16'h0, 1'b0, 1'b0);
        check("wait ctl", ctl[5:2], 20'hc);
        run(24'h8e0000, 1, 8'h00, 16'h0, 1'b0, 1'b0);
        check("stop ctl", {ctl.clear_imask, ctl.halt_osc, ctl.irq_pin_enable}, 20'h7);
    endtask
    task automatic t_cycles();
        logic [7:0] op [5] = '{8'h42, 8'h83, 8'h80, 8'h81, 8'h97};
        logic [3:0] cy [5] = '{4'hb, 4'ha, 4'h9, 4'h6, 4'h2};
        for (int i = 0; i < 5; i++) begin
            run({op[i], 16'h0}, 1, 8'h00, 16'h0, 1'b0, 1'b0);
            check("cycles", dec.cycles, cy[i]);
            check("legal length", {dec.legal, dec.len}, 20'h5);
        end
    endtask
    task automatic t_reg_mem();
        omd_mode_e md [6] = '{OMD_MODE_LITERAL, OMD_MODE_DIRECT, OMD_MODE_EXTENDED,
            OMD_MODE_IDX_WIDE, OMD_MODE_IDX_BYTE, OMD_MODE_IDX_ZERO};
        int ln [6] = '{2, 2, 3, 3, 2, 1};
        logic [3:0] cy [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
        logic [15:0] adr [6] = '{16'h0092, 16'h0092, 16'h9234, 16'h9324, 16'h0182, 16'h00f0};
        for (int i = 0; i < 6; i++) begin
            run({4'ha + 4'(i), 20'h69234}, ln[i], 8'hf0, 16'h0, 1'b0, i[0]);
            check("column mode", dec.mode, md[i]);
            check("row", dec.row, 20'h6);
            check("length", dec.len, 20'(ln[i]));
            check("cycles", dec.cycles, cy[i]);
            check("address", ea, adr[i]);
        end
    endtask
    task automatic t_rmw();
        omd_mode_e md [5] = '{OMD_MODE_DIRECT, OMD_MODE_IMPLIED, OMD_MODE_IMPLIED,
            OMD_MODE_IDX_BYTE, OMD_MODE_IDX_ZERO};
        int ln [5] = '{2, 1, 1, 2, 1};
        for (int i = 0; i < 5; i++) begin
            run({4'h3 + 4'(i), 20'h01200}, ln[i], 8'h07, 16'h0, 1'b0, 1'b0);
            check("rmw mode", dec.mode, md[i]);
            check("rmw class", dec.cls, OMD_CLS_RMW);
        end
    endtask
    task automatic t_branch();
        run(24'h208000, 2, 8'h00, 16'h1000, 1'b1, 1'b1);
        check("branch", {take, tgt}, 20'h10f80);
        run(24'h270500, 2, 8'h00, 16'h2000, 1'b0, 1'b0);
        check("branch", {take, tgt}, 20'h02005);
        run(24'h0140fe, 3, 8'h00, 16'h3000, 1'b1, 1'b1);
        check("bit branch", {take, tgt}, 20'h12ffe);
        check("bit branch address", ea, 20'h40);
        check("bit branch decode", {dec.mode, dec.len, dec.cycles}, 20'h235);
    endtask
    task automatic t_illegal();
        logic [7:0] op [8] = '{8'h31, 8'h45, 8'h5e, 8'h72, 8'h84, 8'h90, 8'ha7, 8'haf};
        for (int i = 0; i < 8; i++) begin
            run({op[i], 16'h0}, 1, 8'h00, 16'h0, 1'b0, 1'b0);
            check("illegal", {ill, dec.legal}, 20'h2);
        end
        run(24'h9d0000, 1, 8'h00, 16'h0, 1'b0, 1'b0);
        check("legal", {ill, dec.legal}, 20'h1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_control();
        t_cycles();
        t_reg_mem();
        t_rmw();
        t_branch();
        t_illegal();
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule

// ===== bench/omd_prog_mem.sv
// Program memory model: hands queued bytes to the decoder, at most one per cycle.
// Assumes the bench loads whole instructions; i_slow puts a gap between bytes.
`timescale 1ns/100ps
module omd_prog_mem (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    logic [7:0] fifo [$];
    logic gap = 1'b0;
    task automatic load(input logic [7:0] b);
        fifo.push_back(b);
    endtask
    // Idle bus inverts the held byte every cycle, alternating between the inverse of the last byte and the last byte
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_byte_valid <= 1'b0;
            o_byte <= 8'h00;
            gap <= 1'b0;
        end else if (fifo.size() != 0 && !gap) begin
            o_byte_valid <= 1'b1;
            o_byte <= fifo.pop_front();
            gap <= i_slow;
        end else begin
            o_byte_valid <= 1'b0;
            o_byte <= ~o_byte;
            gap <= 1'b0;
        end
    end
endmodule

// ===== rtl/omd_decoder.sv
// Opcode map decoder: takes opcode and operand bytes, emits decode record,
// effective address, branch target and core control pulses.
// Assumes program memory presents one byte per i_byte_valid, in program order.
`timescale 1ns/100ps
module omd_decoder
    import omd_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_byte_valid,
    input wire logic [OMD_OP_W-1:0] i_byte,
    input wire logic [OMD_OP_W-1:0] i_index_reg,
    input wire logic [ADDR_W-1:0] i_pc_next,
    input wire logic i_branch_cond,
    output omd_decode_s o_dec,
    output omd_ctl_s o_ctl,
    output logic [ADDR_W-1:0] o_eff_addr,
    output logic [ADDR_W-1:0] o_branch_target,
    output logic o_branch_take,
    output logic o_done,
    output logic o_illegal
);
    omd_state_e state;
    omd_state_e next_state;
    omd_decode_s cur;
    omd_decode_s next_cur;
    omd_decode_s tab;
    omd_ctl_s next_ctl;
    logic [OMD_OP_W-1:0] hi_byte;
    logic [OMD_OP_W-1:0] next_hi_byte;
    logic [ADDR_W-1:0] next_eff_addr;
    logic [ADDR_W-1:0] next_branch_target;
    logic next_branch_take;
    logic next_done;
    logic next_illegal;

    function automatic logic [ADDR_W-1:0] rel_add(input logic [ADDR_W-1:0] base,
                                                  input logic [7:0] off);
        rel_add = base + {{(ADDR_W-8){off[7]}}, off};
    endfunction

    function automatic logic [ADDR_W-1:0] idx_add(input logic [ADDR_W-1:0] off,
                                                  input logic [7:0] idx);
        idx_add = off + {{(ADDR_W-8){1'b0}}, idx};
    endfunction

    omd_table u_table (
        .i_opcode(i_byte),
        .o_dec(tab)
    );

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_hi_byte = hi_byte;
        next_eff_addr = o_eff_addr;
        next_branch_target = o_branch_target;
        next_branch_take = 1'b0;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_ctl = '0;
        case (state)
            OMD_ST_IDLE: begin
                if (i_byte_valid) begin
                    next_cur = tab;
                    next_eff_addr = '0;
                    if (!tab.legal) begin
                        next_illegal = 1'b1;
                        next_done = 1'b1;
                    end else if (tab.mode == OMD_MODE_RELATIVE) begin
                        next_state = OMD_ST_REL;
                    end else if (tab.mode == OMD_MODE_IDX_ZERO) begin
                        next_eff_addr = idx_add('0, i_index_reg);
                        next_done = 1'b1;
                    end else if (tab.len == 2'h1) begin
                        next_done = 1'b1;
                        case (i_byte)
                            OMD_OP_INDEX_TO_ACC_MOVE: begin
                                next_ctl.index_to_acc_move = 1'b1;
                                next_ctl.keep_flags = 1'b1;
                            end
                            OMD_OP_WAIT: begin
                                next_ctl.clear_imask = 1'b1;
                                next_ctl.halt_cpu_clk = 1'b1;
                            end
                            OMD_OP_STOP: begin
                                next_ctl.clear_imask = 1'b1;
                                next_ctl.halt_osc = 1'b1;
                                next_ctl.irq_pin_enable = 1'b1;
                            end
                            default: next_ctl = '0;
                        endcase
                    end else if (tab.len == 2'h3 && tab.mode != OMD_MODE_DIR_REL) begin
                        next_state = OMD_ST_OPND_HI;
                    end else begin
                        next_state = OMD_ST_OPND_LO;
                    end
                end
            end
            OMD_ST_OPND_HI: begin
                if (i_byte_valid) begin
                    next_hi_byte = i_byte;
                    next_state = OMD_ST_OPND_LO;
                end
            end
            OMD_ST_OPND_LO: begin
                if (i_byte_valid) begin
                    case (cur.mode)
                        OMD_MODE_EXTENDED:
                            next_eff_addr = ADDR_W'({hi_byte, i_byte});
                        OMD_MODE_IDX_WIDE:
                            next_eff_addr = idx_add(ADDR_W'({hi_byte, i_byte}),
                                                    i_index_reg);
                        OMD_MODE_IDX_BYTE:
                            next_eff_addr = idx_add(ADDR_W'(i_byte), i_index_reg);
                        default: next_eff_addr = ADDR_W'(i_byte);
                    endcase
                    if (cur.mode == OMD_MODE_DIR_REL) begin
                        next_state = OMD_ST_REL;
                    end else begin
                        next_state = OMD_ST_DONE;
                    end
                end
            end
            OMD_ST_REL: begin
                if (i_byte_valid) begin
                    next_branch_target = rel_add(i_pc_next, i_byte);
                    next_branch_take = i_branch_cond;
                    next_state = OMD_ST_DONE;
                end
            end
            OMD_ST_DONE: begin
                next_done = 1'b1;
                next_state = OMD_ST_IDLE;
            end
            default: next_state = OMD_ST_IDLE;
        endcase
        if (state == OMD_ST_DONE) begin
            next_branch_take = o_branch_take;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= OMD_ST_IDLE;
            cur <= '0;
            hi_byte <= '0;
            o_dec <= '0;
            o_ctl <= '0;
            o_eff_addr <= '0;
            o_branch_target <= '0;
            o_branch_take <= 1'b0;
            o_done <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            hi_byte <= next_hi_byte;
            o_dec <= next_cur;
            o_ctl <= next_ctl;
            o_eff_addr <= next_eff_addr;
            o_branch_target <= next_branch_target;
            o_branch_take <= next_branch_take;
            o_done <= next_done;
            o_illegal <= next_illegal;
        end
    end
endmodule

// ===== rtl/omd_pkg.sv
// Package for the opcode map decoder: modes, classes, decode record, timing.
// Assumes a single core clock domain.
package omd_pkg;
    localparam int OMD_OP_W = 8;
    localparam int OMD_NIB_W = 4;
    localparam int OMD_CYC_W = 4;
    localparam int OMD_LEN_W = 2;
    localparam int OMD_IDX_W = 4;
    localparam logic [3:0] OMD_HI_BITSET = 4'h1;
    localparam logic [3:0] OMD_HI_REL = 4'h2;
    localparam logic [3:0] OMD_HI_RMW_DIR = 4'h3;
    localparam logic [3:0] OMD_HI_RMW_ACC = 4'h4;
    localparam logic [3:0] OMD_HI_RMW_IDX = 4'h5;
    localparam logic [3:0] OMD_HI_RMW_IX1 = 4'h6;
    localparam logic [3:0] OMD_HI_RMW_IX = 4'h7;
    localparam logic [3:0] OMD_HI_CTL_A = 4'h8;
    localparam logic [3:0] OMD_HI_CTL_B = 4'h9;
    localparam logic [3:0] OMD_HI_IMM = 4'ha;
    localparam logic [3:0] OMD_HI_DIR = 4'hb;
    localparam logic [3:0] OMD_HI_EXT = 4'hc;
    localparam logic [3:0] OMD_HI_IX2 = 4'hd;
    localparam logic [3:0] OMD_HI_IX1 = 4'he;
    localparam logic [3:0] OMD_HI_IX = 4'hf;
    localparam logic [7:0] OMD_OP_INDEX_TO_ACC_MOVE = 8'h9f;
    localparam logic [7:0] OMD_OP_WAIT = 8'h8f;
    localparam logic [7:0] OMD_OP_STOP = 8'h8e;
    localparam logic [7:0] OMD_OP_MULTIPLY_OP = 8'h42;
    localparam logic [7:0] OMD_OP_SOFT_TRAP = 8'h83;
    localparam logic [7:0] OMD_OP_TRAP_RETURN = 8'h80;
    localparam logic [3:0] OMD_CYC_INDEX_TO_ACC_MOVE = 4'h2;
    localparam logic [3:0] OMD_CYC_MULTIPLY_OP = 4'hb;
    localparam logic [3:0] OMD_CYC_SOFT_TRAP = 4'ha;
    localparam logic [3:0] OMD_CYC_TRAP_RETURN = 4'h9;
    localparam logic [3:0] OMD_CYC_BIT_BRANCH = 4'h5;
    localparam logic [1:0] OMD_LEN_BIT_BRANCH = 2'h3;

    typedef enum logic [3:0] {
        OMD_MODE_IMPLIED = 4'h0,
        OMD_MODE_LITERAL = 4'h1,
        OMD_MODE_DIRECT = 4'h2,
        OMD_MODE_EXTENDED = 4'h3,
        OMD_MODE_IDX_WIDE = 4'h4,
        OMD_MODE_IDX_BYTE = 4'h5,
        OMD_MODE_IDX_ZERO = 4'h6,
        OMD_MODE_RELATIVE = 4'h7,
        OMD_MODE_DIR_REL = 4'h8
    } omd_mode_e;

    typedef enum logic [2:0] {
        OMD_CLS_BIT_BRANCH = 3'h0,
        OMD_CLS_BIT_SETCLR = 3'h1,
        OMD_CLS_BRANCH = 3'h2,
        OMD_CLS_RMW = 3'h3,
        OMD_CLS_CONTROL = 3'h4,
        OMD_CLS_REG_MEM = 3'h5
    } omd_class_e;

    typedef enum logic [4:0] {
        OMD_ST_IDLE = 5'b00001,
        OMD_ST_OPND_HI = 5'b00010,
        OMD_ST_OPND_LO = 5'b00100,
        OMD_ST_REL = 5'b01000,
        OMD_ST_DONE = 5'b10000
    } omd_state_e;

    typedef struct packed {
        logic legal;
        omd_class_e cls;
        omd_mode_e mode;
        logic [OMD_NIB_W-1:0] row;
        logic [OMD_LEN_W-1:0] len;
        logic [OMD_CYC_W-1:0] cycles;
    } omd_decode_s;

    typedef struct packed {
        logic clear_imask;
        logic halt_cpu_clk;
        logic halt_osc;
        logic irq_pin_enable;
        logic index_to_acc_move;
        logic keep_flags;
    } omd_ctl_s;
endpackage

// ===== rtl/omd_table.sv
// Combinational opcode table: class, mode, length, cycles, legality.
// Assumes the opcode byte is stable for the cycle it is looked up.
`timescale 1ns/100ps
module omd_table
    import omd_pkg::*;
(
    input wire logic [OMD_OP_W-1:0] i_opcode,
    output omd_decode_s o_dec
);
    logic [3:0] hi;
    logic [3:0] lo;
    logic ill;

    always_comb begin
        hi = i_opcode[7:4];
        lo = i_opcode[3:0];
        ill = 1'b0;
        o_dec = '0;
        o_dec.row = lo;
        case (hi)
            4'h0: begin
                o_dec.cls = OMD_CLS_BIT_BRANCH;
                o_dec.mode = OMD_MODE_DIR_REL;
                o_dec.len = OMD_LEN_BIT_BRANCH;
                o_dec.cycles = OMD_CYC_BIT_BRANCH;
            end
            OMD_HI_BITSET: begin
                o_dec.cls = OMD_CLS_BIT_SETCLR;
                o_dec.mode = OMD_MODE_DIRECT;
                o_dec.len = 2'h2;
                o_dec.cycles = 4'h5;
            end
            OMD_HI_REL: begin
                o_dec.cls = OMD_CLS_BRANCH;
                o_dec.mode = OMD_MODE_RELATIVE;
                o_dec.len = 2'h2;
                o_dec.cycles = 4'h3;
            end
            OMD_HI_RMW_DIR, OMD_HI_RMW_ACC, OMD_HI_RMW_IDX,
            OMD_HI_RMW_IX1, OMD_HI_RMW_IX: begin
                o_dec.cls = OMD_CLS_RMW;
                ill = (lo == 4'h1) || (lo == 4'h5) || (lo == 4'hb) || (lo == 4'he)
                    || (lo == 4'h2 && hi != OMD_HI_RMW_ACC)
                    || (lo == 4'h8 && (hi == OMD_HI_RMW_DIR || hi == OMD_HI_RMW_IDX
                        || hi == OMD_HI_RMW_IX1))
                    || (lo == 4'hc && hi != OMD_HI_RMW_DIR && hi != OMD_HI_RMW_IX);
                case (hi)
                    OMD_HI_RMW_DIR: begin
                        o_dec.mode = OMD_MODE_DIRECT;
                        o_dec.len = 2'h2;
                        o_dec.cycles = (lo == 4'hd) ? 4'h4 : 4'h5;
                    end
                    OMD_HI_RMW_IX1: begin
                        o_dec.mode = OMD_MODE_IDX_BYTE;
                        o_dec.len = 2'h2;
                        o_dec.cycles = (lo == 4'hd) ? 4'h5 : 4'h6;
                    end
                    OMD_HI_RMW_IX: begin
                        o_dec.mode = OMD_MODE_IDX_ZERO;
                        o_dec.len = 2'h1;
                        o_dec.cycles = (lo == 4'hd) ? 4'h4 : 4'h5;
                    end
                    default: begin
                        o_dec.mode = OMD_MODE_IMPLIED;
                        o_dec.len = 2'h1;
                        o_dec.cycles = (lo == 4'h2) ? OMD_CYC_MULTIPLY_OP : 4'h3;
                    end
                endcase
            end
            OMD_HI_CTL_A, OMD_HI_CTL_B: begin
                o_dec.cls = OMD_CLS_CONTROL;
                o_dec.mode = OMD_MODE_IMPLIED;
                o_dec.len = 2'h1;
                o_dec.cycles = 4'h2;
                if (hi == OMD_HI_CTL_A) begin
                    case (lo)
                        4'h0: o_dec.cycles = OMD_CYC_TRAP_RETURN;
                        4'h1: o_dec.cycles = 4'h6;
                        4'h3: o_dec.cycles = OMD_CYC_SOFT_TRAP;
                        4'he, 4'hf: o_dec.cycles = 4'h2;
                        default: ill = 1'b1;
                    endcase
                end else begin
                    ill = (lo < 4'h7) || (lo == 4'he);
                end
            end
            default: begin
                o_dec.cls = OMD_CLS_REG_MEM;
                ill = (lo == 4'h7 && hi == OMD_HI_IMM) || (lo == 4'hf && hi == OMD_HI_IMM)
                    || (lo == 4'hc && hi == OMD_HI_IMM);
                case (hi)
                    OMD_HI_IMM: begin
                        o_dec.mode = (lo == 4'hd) ? OMD_MODE_RELATIVE : OMD_MODE_LITERAL;
                        o_dec.len = 2'h2;
                        o_dec.cycles = (lo == 4'hd) ? 4'h6 : 4'h2;
                    end
                    OMD_HI_DIR: begin
                        o_dec.mode = OMD_MODE_DIRECT;
                        o_dec.len = 2'h2;
                        o_dec.cycles = 4'h3;
                    end
                    OMD_HI_EXT: begin
                        o_dec.mode = OMD_MODE_EXTENDED;
                        o_dec.len = 2'h3;
                        o_dec.cycles = 4'h4;
                    end
                    OMD_HI_IX2: begin
                        o_dec.mode = OMD_MODE_IDX_WIDE;
                        o_dec.len = 2'h3;
                        o_dec.cycles = 4'h5;
                    end
                    OMD_HI_IX1: begin
                        o_dec.mode = OMD_MODE_IDX_BYTE;
                        o_dec.len = 2'h2;
                        o_dec.cycles = 4'h4;
                    end
                    default: begin
                        o_dec.mode = OMD_MODE_IDX_ZERO;
                        o_dec.len = 2'h1;
                        o_dec.cycles = 4'h3;
                    end
                endcase
                if (hi != OMD_HI_IMM) begin
                    if (lo == 4'h7 || lo == 4'hf) begin
                        o_dec.cycles = o_dec.cycles + 4'h1;
                    end else if (lo == 4'hc) begin
                        o_dec.cycles = o_dec.cycles - 4'h1;
                    end else if (lo == 4'hd) begin
                        o_dec.cycles = o_dec.cycles + 4'h2;
                    end
                end
            end
        endcase
        o_dec.legal = ~ill;
        if (ill) begin
            o_dec.len = 2'h1;
            o_dec.cycles = 4'h1;
        end
    end
endmodule
